//--- design/afc_filter_chain.sv
// Accelerometer filter chain top: APB registers, mode decode, sample
// timing and output routing; gyro sleep state decode.
// Assumes a 100 MHz clock; sample input is one word held by the sensor.
`timescale 1ns/1ps
module afc_filter_chain
  import afc_pkg::*;
#(
  parameter int W = 16
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Raw sample from the converter
  input wire logic signed [W-1:0] rawSample,
  // Filtered data paths
  output logic signed [W-1:0] outData,
  output logic signed [W-1:0] irqData,
  output logic signed [W-1:0] slopeData,
  output logic signed [W-1:0] orientData,
  output logic sampleStb,
  // Analog and gyro controls
  output logic aaEnable,
  output logic [15:0] aaBandwidth,
  output logic gyroSleep,
  output logic gyroDriveOn
);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [7:0] accelCtrl_ff; // Rate, bandwidth, mode bits
  logic [7:0] filtCtrl_ff; // Composite filter control
  logic [7:0] gyroCtrl_ff; // Gyro rate and sleep
  logic [31:0] divCnt_ff; // Sample period counter
  logic [31:0] nxt_divCnt;
  logic [31:0] period;
  afc_cfg_t cfg;
  logic [3:0] lp1Shift;
  logic [3:0] cutShift;
  logic signed [W-1:0] lp1V;
  logic signed [W-1:0] lp2V;
  logic signed [W-1:0] hpV;
  logic signed [W-1:0] slV;
  logic apbWr;
  logic apbRd;
  logic addrOk;

  initial
  begin
    if (W < 4 || W > 24)
      $error("afc_filter_chain: W out of range");
  end

  // ----------------------------------------------------------------
  // Decode functions
  // ----------------------------------------------------------------

  // Power mode from rate code and high-performance disable
  function automatic afc_pmode_t mode_of(input logic [3:0] rate, input logic hpDis);
    afc_pmode_t m;
    m = AFC_PM_HIGH;
    if (rate == AFC_RATE_PD || rate > AFC_RATE_MAX)
      m = AFC_PM_DOWN;
    else if (hpDis && rate < 4'h4)
      m = AFC_PM_LOW;
    else if (hpDis && rate <= AFC_RATE_208)
      m = AFC_PM_NORMAL;
    return m;
  endfunction

  // Bandwidth field to Hz
  function automatic afc_hz_t bw_field(input logic [1:0] f);
    afc_hz_t h;
    case (f)
      2'b00: h = 16'd400;
      2'b01: h = 16'd200;
      2'b10: h = 16'd100;
      default: h = 16'd50;
    endcase
    return h;
  endfunction

  // Cutoff field to divider of the data rate
  function automatic logic [8:0] cut_div(input logic [1:0] f, input logic lp);
    logic [8:0] d;
    case (f)
      2'b00: d = lp ? 9'd50 : 9'd4;
      2'b01: d = 9'd100;
      2'b10: d = 9'd9;
      default: d = 9'd400;
    endcase
    return d;
  endfunction

  // Divider to exponential-average shift, log2 rounded down
  function automatic logic [3:0] div_shift(input logic [8:0] d);
    logic [3:0] s;
    s = 4'h1;
    for (int i = 1; i < 9; i++)
      if (d >= 9'(1 << i))
        s = 4'(i);
    return s;
  endfunction

  // ----------------------------------------------------------------
  // Configuration decode
  // ----------------------------------------------------------------
  always_comb
  begin
    cfg.pmode = mode_of(accelCtrl_ff[AFC_POS_RATE +: 4], accelCtrl_ff[AFC_POS_HPDIS]);
    // Anti-alias bandwidth
    if (accelCtrl_ff[AFC_POS_BWSCAL])
      cfg.aaBw = bw_field(accelCtrl_ff[AFC_POS_BW +: 2]);
    else
    begin
      case (accelCtrl_ff[AFC_POS_RATE +: 4])
        4'h1, 4'h2, 4'h3, 4'h4: cfg.aaBw = 16'd50;
        4'h5: cfg.aaBw = 16'd100;
        4'h6: cfg.aaBw = 16'd200;
        4'h7, 4'h8: cfg.aaBw = 16'd400;
        default: cfg.aaBw = 16'd0;
      endcase
    end
    // First low-pass cutoff
    if (cfg.pmode != AFC_PM_HIGH)
      cfg.lp1Cut = 16'd742;
    else
    begin
      case (accelCtrl_ff[AFC_POS_RATE +: 4])
        4'h1: cfg.lp1Cut = 16'd23;
        4'h2: cfg.lp1Cut = 16'd46;
        4'h3: cfg.lp1Cut = 16'd92;
        4'h4: cfg.lp1Cut = 16'd184;
        4'h5: cfg.lp1Cut = 16'd369;
        4'h6: cfg.lp1Cut = 16'd742;
        4'h7, 4'h9: cfg.lp1Cut = 16'd1517;
        default: cfg.lp1Cut = 16'd3320;
      endcase
    end
    // Composite enable is an OR of select and function enable
    cfg.compEn = filtCtrl_ff[AFC_POS_FDS] | filtCtrl_ff[AFC_POS_FUNC];
    cfg.wakeHp = filtCtrl_ff[AFC_POS_FDS];
    // Output selection, low-pass first
    if (filtCtrl_ff[AFC_POS_LP2EN])
      cfg.outSel = AFC_SEL_LP2;
    else if (filtCtrl_ff[AFC_POS_HPEN])
      cfg.outSel = (filtCtrl_ff[AFC_POS_CUT +: 2] == 2'b00) ? AFC_SEL_SLOPE : AFC_SEL_HP;
    else
      cfg.outSel = AFC_SEL_NONE;
    cfg.cutDiv = cut_div(filtCtrl_ff[AFC_POS_CUT +: 2], filtCtrl_ff[AFC_POS_LP2EN]);
    // Second low-pass uses its own divider table
    cutShift = div_shift(cut_div(filtCtrl_ff[AFC_POS_CUT +: 2], 1'b1));
    // First stage shift: cutoff near half rate is a light average
    lp1Shift = (cfg.lp1Cut >= 16'd742) ? 4'h1 : 4'h2;
    period = (cfg.pmode == AFC_PM_DOWN) ? 32'd0
      : 32'(AFC_CLK_HZ / AFC_RATE_HZ[accelCtrl_ff[AFC_POS_RATE +: 4]]);
  end

  // ----------------------------------------------------------------
  // Sample timing: one strobe per output sample
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_divCnt = divCnt_ff + 32'd1;
    if (period == 32'd0 || nxt_divCnt >= period)
      nxt_divCnt = 32'd0;
  end

  // Counter is held at zero in power-down so no stage advances
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      divCnt_ff <= '0;
      sampleStb <= 1'b0;
    end
    else
    begin
      divCnt_ff <= nxt_divCnt;
      sampleStb <= (period != 32'd0) && (nxt_divCnt == 32'd0);
    end
  end

  // ----------------------------------------------------------------
  // Filter datapath
  // ----------------------------------------------------------------
  afc_filter_stage #(.W(W)) uStage
  (
    .clock(clock),
    .rstn(rstn),
    .sampleStb((period != 32'd0) && (nxt_divCnt == 32'd0)),
    .sampleIn(rawSample),
    .lp1Shift(lp1Shift),
    .cutShift(cutShift),
    .compEn(cfg.compEn),
    .lp1Out(lp1V),
    .lp2Out(lp2V),
    .hpOut(hpV),
    .slopeOut(slV)
  );

  // Routing: output/FIFO path and interrupt path chosen separately
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      outData <= '0;
      irqData <= '0;
      slopeData <= '0;
      orientData <= '0;
    end
    else
    begin
      case (cfg.outSel)
        AFC_SEL_LP2: outData <= lp2V;
        AFC_SEL_HP: outData <= hpV;
        AFC_SEL_SLOPE: outData <= slV;
        default: outData <= lp1V;
      endcase
      // Wake-up path: slope or high-pass
      irqData <= cfg.wakeHp ? hpV : slV;
      // Activity and tap detectors always see the slope
      slopeData <= slV;
      orientData <= filtCtrl_ff[AFC_POS_ORIENT] ? lp2V : lp1V;
    end
  end

  // ----------------------------------------------------------------
  // Analog and gyro controls
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      aaEnable <= 1'b0;
      aaBandwidth <= '0;
      gyroSleep <= 1'b0;
      gyroDriveOn <= 1'b0;
    end
    else
    begin
      // Bypassed outside high-performance and when rate leaves it unused
      aaEnable <= (cfg.pmode == AFC_PM_HIGH) && (cfg.aaBw != 16'd0);
      aaBandwidth <= (cfg.pmode == AFC_PM_HIGH) ? cfg.aaBw : 16'd0;
      // Sleep regardless of gyro rate once powered up
      gyroSleep <= (gyroCtrl_ff[AFC_POS_GRATE +: 4] != AFC_RATE_PD)
        && gyroCtrl_ff[AFC_POS_GSLEEP];
      // Drive stays on in sleep for a fast wake
      gyroDriveOn <= (gyroCtrl_ff[AFC_POS_GRATE +: 4] != AFC_RATE_PD);
    end
  end

  // ----------------------------------------------------------------
  // APB slave: zero wait state, error on unmapped address
  // ----------------------------------------------------------------
  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && !penable && !pwrite;
  assign addrOk = (paddr <= AFC_OFF_DATA_SLOPE) && (paddr[1:0] == 2'b00);

  // Register writes
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      accelCtrl_ff <= AFC_RST_ACCEL_CTRL;
      filtCtrl_ff <= AFC_RST_FILT_CTRL;
      gyroCtrl_ff <= AFC_RST_GYRO_CTRL;
    end
    else if (apbWr)
    begin
      case (paddr)
        AFC_OFF_ACCEL_CTRL: accelCtrl_ff <= pwdata[7:0];
        AFC_OFF_FILT_CTRL: filtCtrl_ff <= {1'b0, pwdata[6:0]};
        AFC_OFF_GYRO_CTRL: gyroCtrl_ff <= {3'b000, pwdata[4:0]};
        default: ;
      endcase
    end
  end

  // Read data captured in setup so it is stable in the access phase
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !addrOk;
      if (apbRd)
      begin
        case (paddr)
          AFC_OFF_ACCEL_CTRL: prdata <= {24'h000000, accelCtrl_ff};
          AFC_OFF_FILT_CTRL: prdata <= {24'h000000, filtCtrl_ff};
          AFC_OFF_GYRO_CTRL: prdata <= {24'h000000, gyroCtrl_ff};
          AFC_OFF_STATUS: prdata <= {14'h0000, cfg.outSel, aaBandwidth};
          AFC_OFF_DATA_OUT: prdata <= 32'(outData);
          AFC_OFF_DATA_IRQ: prdata <= 32'(irqData);
          AFC_OFF_DATA_SLOPE: prdata <= 32'(slopeData);
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

//--- include/afc_pkg.sv
// Constants and carrier types for the accelerometer filter chain block.
// Assumes a single 100 MHz clock domain and an APB register slave.
//
// Behaviour
// - Gyro sleeps when sleep bit set, unless powered down
// - Sleep keeps mass drive running
// - Anti-alias filter only in high-performance mode
// - Scaling bit one: bandwidth from bandwidth field
// - Scaling bit zero: bandwidth from data rate
// - First low-pass cutoff follows data rate in high-performance mode, fixed otherwise
// - Composite filters routed independently to outputs
// - Composite filters enabled by select OR function
// - Select bit picks wake-up slope or high-pass
// - Both output enables zero: no filter
// - Low-pass output enable has priority
// - Cutoff field picks slope or high-pass
// - Cutoff field sets second low-pass cutoff
// - Orientation select routes low-pass to orientation
// - Slope is half the sample difference
// - Slope feeds activity and tap detection
// - Rate field and disable bit pick rate, mode
package afc_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] AFC_OFF_ACCEL_CTRL = 8'h00;
  localparam logic [7:0] AFC_OFF_FILT_CTRL = 8'h04;
  localparam logic [7:0] AFC_OFF_GYRO_CTRL = 8'h08;
  localparam logic [7:0] AFC_OFF_STATUS = 8'h0C;
  localparam logic [7:0] AFC_OFF_DATA_OUT = 8'h10;
  localparam logic [7:0] AFC_OFF_DATA_IRQ = 8'h14;
  localparam logic [7:0] AFC_OFF_DATA_SLOPE = 8'h18;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  // Accel control: rate[3:0], bw[5:4], hp disable[6], bw scaling[7]
  localparam int AFC_POS_RATE = 0;
  localparam int AFC_POS_BW = 4;
  localparam int AFC_POS_HPDIS = 6;
  localparam int AFC_POS_BWSCAL = 7;
  // Filter control: cutoff[1:0], lp2en[2], hpen[3], fds[4], func[5], orient[6]
  localparam int AFC_POS_CUT = 0;
  localparam int AFC_POS_LP2EN = 2;
  localparam int AFC_POS_HPEN = 3;
  localparam int AFC_POS_FDS = 4;
  localparam int AFC_POS_FUNC = 5;
  localparam int AFC_POS_ORIENT = 6;
  // Gyro control: gyro rate[3:0], sleep[4]
  localparam int AFC_POS_GRATE = 0;
  localparam int AFC_POS_GSLEEP = 4;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] AFC_RST_ACCEL_CTRL = 8'h00;
  localparam logic [7:0] AFC_RST_FILT_CTRL = 8'h00;
  localparam logic [7:0] AFC_RST_GYRO_CTRL = 8'h00;

  // ----------------------------------------------------------------
  // Rate codes and timing
  // ----------------------------------------------------------------
  localparam logic [3:0] AFC_RATE_PD = 4'h0;
  localparam logic [3:0] AFC_RATE_208 = 4'h5;
  localparam logic [3:0] AFC_RATE_MAX = 4'hA;
  localparam int AFC_CLK_HZ = 100000000;
  // Output data rate per rate code, in Hz
  localparam int AFC_RATE_HZ [11] = '{0, 13, 26, 52, 104, 208, 416, 833, 1660, 3330, 6660};

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    AFC_PM_DOWN = 2'b00,
    AFC_PM_LOW = 2'b01,
    AFC_PM_NORMAL = 2'b10,
    AFC_PM_HIGH = 2'b11
  } afc_pmode_t;

  // Anti-alias bandwidth in Hz, 0 meaning filter bypassed
  typedef logic [15:0] afc_hz_t;

  typedef enum logic [1:0]
  {
    AFC_GY_DOWN = 2'b00,
    AFC_GY_SLEEP = 2'b01,
    AFC_GY_ACTIVE = 2'b10
  } afc_gstate_t;

  // Composite output selection
  typedef enum logic [1:0]
  {
    AFC_SEL_NONE = 2'b00,
    AFC_SEL_LP2 = 2'b01,
    AFC_SEL_HP = 2'b10,
    AFC_SEL_SLOPE = 2'b11
  } afc_sel_t;

  // Decoded filter configuration
  typedef struct packed
  {
    afc_pmode_t pmode;
    afc_hz_t aaBw;
    afc_hz_t lp1Cut;
    logic [8:0] cutDiv;
    afc_sel_t outSel;
    logic compEn;
    logic wakeHp;
  } afc_cfg_t;

endpackage

//--- design/afc_filter_stage.sv
// One axis of the composite filter: first low-pass, second low-pass,
// high-pass and slope, advancing on each sample strobe.
// Assumes samples arrive as signed words with a one-cycle strobe.
`timescale 1ns/1ps
module afc_filter_stage
  import afc_pkg::*;
#(
  parameter int W = 16
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Sample in
  input wire logic sampleStb,
  input wire logic signed [W-1:0] sampleIn,
  // Configuration
  input wire logic [3:0] lp1Shift,
  input wire logic [3:0] cutShift,
  input wire logic compEn,
  // Filtered results, registered
  output logic signed [W-1:0] lp1Out,
  output logic signed [W-1:0] lp2Out,
  output logic signed [W-1:0] hpOut,
  output logic signed [W-1:0] slopeOut
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic signed [W+7:0] lp1Acc_ff; // Extra bits keep shifted fraction
  logic signed [W+7:0] lp2Acc_ff;
  logic signed [W-1:0] prev_ff; // Previous first-stage sample
  logic signed [W+7:0] nxt_lp1;
  logic signed [W+7:0] nxt_lp2;
  logic signed [W-1:0] lp1Now;

  initial
  begin
    if (W < 4 || W > 24)
      $error("afc_filter_stage: W out of range");
  end

  // Exponential averages; shift approximates cutoff divider
  always_comb
  begin
    nxt_lp1 = lp1Acc_ff + ((((W+8)'(sampleIn) <<< 8) - lp1Acc_ff) >>> lp1Shift);
    lp1Now = lp1Acc_ff[W+7:8];
    nxt_lp2 = lp2Acc_ff + ((((W+8)'(lp1Now) <<< 8) - lp2Acc_ff) >>> cutShift);
  end

  // First stage always runs once per sample
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      lp1Acc_ff <= '0;
    else if (sampleStb)
      lp1Acc_ff <= nxt_lp1;
  end

  // Composite stages run only when enabled, once per sample
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      lp2Acc_ff <= '0;
      prev_ff <= '0;
      slopeOut <= '0;
      hpOut <= '0;
    end
    else if (sampleStb && compEn)
    begin
      lp2Acc_ff <= nxt_lp2;
      prev_ff <= lp1Now;
      // Half difference of successive samples
      slopeOut <= W'((($signed({lp1Now[W-1], lp1Now}) - $signed({prev_ff[W-1], prev_ff})))
        >>> 1);
      hpOut <= W'($signed({lp1Now[W-1], lp1Now}) - $signed({nxt_lp2[W+7], nxt_lp2[W+7:8]}));
    end
  end

  assign lp1Out = lp1Now;
  assign lp2Out = lp2Acc_ff[W+7:8];

endmodule

//--- dv/afc_filter_chain_checker.sv
// Checker for the filter chain top: sees only the top module's ports.
// Assumes writes land when psel, penable and pready are high.
`timescale 1ns/1ps
module afc_filter_chain_checker
  import afc_pkg::*;
#(
  parameter int W = 16
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // APB slave side
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Sample stream
  input wire logic signed [W-1:0] rawSample,
  input wire logic signed [W-1:0] outData,
  input wire logic signed [W-1:0] irqData,
  input wire logic signed [W-1:0] slopeData,
  input wire logic signed [W-1:0] orientData,
  input wire logic sampleStb,
  // Analog and gyro controls
  input wire logic aaEnable,
  input wire logic [15:0] aaBandwidth,
  input wire logic gyroSleep,
  input wire logic gyroDriveOn
);
  // ----------------------------------------------------------------
  // Register mirror
  // ----------------------------------------------------------------
  logic [7:0] accCtrl_ff; // Mirror of accel control
  logic [7:0] gyroCtrl_ff; // Mirror of gyro control
  logic [1:0] cfgAge_ff; // Cycles since the last write, saturating
  logic wrDone; // A write completes at this edge
  logic [3:0] rate; // Mirrored accel rate code
  logic highPerf; // Accel runs in high-performance mode
  logic [15:0] bwWant; // Bandwidth the decode should give
  assign wrDone = psel && penable && pready && pwrite;
  assign rate = accCtrl_ff[AFC_POS_RATE +: 4];
  assign highPerf = rate != AFC_RATE_PD && rate <= AFC_RATE_MAX
    && (!accCtrl_ff[AFC_POS_HPDIS] || rate >= 4'h6);
  assign bwWant = bwExp(accCtrl_ff);

  // Anti-alias bandwidth in Hz, zero where the rate table leaves the filter unused
  function automatic logic [15:0] bwExp(input logic [7:0] acc);
    if (acc[AFC_POS_BWSCAL])
      return 16'h0190 >> acc[AFC_POS_BW +: 2];
    case (acc[3:0])
      4'h1, 4'h2, 4'h3, 4'h4: return 16'h0032;
      4'h5: return 16'h0064;
      4'h6: return 16'h00C8;
      4'h7, 4'h8: return 16'h0190;
      default: return 16'h0000;
    endcase
  endfunction

  // Capture configuration writes as the slave takes them
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      accCtrl_ff <= AFC_RST_ACCEL_CTRL;
      gyroCtrl_ff <= AFC_RST_GYRO_CTRL;
    end
    else if (wrDone && paddr == AFC_OFF_ACCEL_CTRL)
      accCtrl_ff <= pwdata[7:0];
    else if (wrDone && paddr == AFC_OFF_GYRO_CTRL)
      gyroCtrl_ff <= pwdata[7:0];
  end

  // Outputs judged once the registered decode settled
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cfgAge_ff <= 2'h0;
    else if (wrDone)
      cfgAge_ff <= 2'h0;
    else if (cfgAge_ff != 2'h3)
      cfgAge_ff <= cfgAge_ff + 2'h1;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  chk_gyro_sleep: assert property (cfgAge_ff == 2'h3 |-> gyroSleep ==
    (gyroCtrl_ff[AFC_POS_GRATE +: 4] != 4'h0 && gyroCtrl_ff[AFC_POS_GSLEEP]))
    else $error("gyro sleep state wrong");
  chk_sleep_drive: assert property (cfgAge_ff == 2'h3 && gyroSleep |-> gyroDriveOn)
    else $error("mass drive off in sleep");
  chk_aa_enable: assert property (cfgAge_ff == 2'h3 |->
    aaEnable == (highPerf && bwWant != 16'h0000))
    else $error("anti-alias enable wrong");
  chk_aa_field: assert property (cfgAge_ff == 2'h3 && highPerf && accCtrl_ff[7]
    |-> aaBandwidth == bwWant)
    else $error("bandwidth from field wrong");
  chk_aa_rate: assert property (cfgAge_ff == 2'h3 && highPerf && !accCtrl_ff[7]
    |-> aaBandwidth == bwWant)
    else $error("bandwidth from rate wrong");
  chk_apb_ready: assert property (psel && !penable |=> pready)
    else $error("no answer in access phase");
  chk_apb_refuse: assert property (psel && !penable && (paddr[1:0] != 2'h0 || paddr > 8'h18)
    |=> pslverr && (pwrite || prdata == 32'h0))
    else $error("bad address not refused");
  chk_strobe_pulse: assert property (sampleStb |=> !sampleStb)
    else $error("sample strobe longer than a cycle");
  chk_no_strobe_pd: assert property (cfgAge_ff == 2'h3 && (rate == 4'h0 || rate > 4'hA)
    |-> !sampleStb)
    else $error("strobe in power-down");
  chk_slope_hold: assert property (!$stable(slopeData) |-> sampleStb || $past(sampleStb))
    else $error("slope moved between samples");

  cov_strobe: cover property (sampleStb);
  cov_refuse: cover property (pready && pslverr);
  cov_sleep: cover property (gyroSleep && gyroDriveOn);
  cov_aa50: cover property (aaEnable && aaBandwidth == 16'h0032);
endmodule

bind afc_filter_chain afc_filter_chain_checker #(.W(W)) u_chk (.*);

//--- dv/afc_sample_source.sv
// Converter stand-in: a ramp that steps once per output sample.
// Assumes the block latches rawSample before sampleStb.
`timescale 1ns/1ps
module afc_sample_source
  import afc_pkg::*;
#(
  parameter int W = 16,
  parameter logic [15:0] STEP = 16'hFFFA
)
(
  // Clock and reset
  input wire logic clock,
  input wire logic rstn,
  // Sample handshake
  input wire logic sampleStb,
  output logic signed [W-1:0] rawSample
);
  logic signed [W-1:0] level_ff; // Word held by the converter
  assign rawSample = level_ff;

  // Step after each consumed sample; a negative step also exercises sign extension
  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      level_ff <= '0;
    else if (sampleStb)
      level_ff <= level_ff + W'(STEP);
  end
endmodule

//--- dv/tb_afc_filter_chain.sv
// Self-checking bench for the filter chain top, fed by a ramp source.
// Assumes the checker binds itself to the top; one 100 MHz clock.
`timescale 1ns/1ps
module tb_afc_filter_chain
  import afc_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int W = 16;
  localparam int PERIOD_A = 15015; // Cycles per sample at the top rate code
  typedef struct packed
  {
    logic [7:0] acc;
    logic [7:0] filt;
    logic [7:0] gyro;
    logic [15:0] bw;
    logic [1:0] sel;
    logic en;
    logic gs;
    logic gd;
    logic [2:0] spare;
  } afc_row_t;
  logic clock = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr;
  logic signed [W-1:0] rawSample;
  logic signed [W-1:0] slopeData;
  logic sampleStb;
  logic aaEnable;
  logic [15:0] aaBandwidth;
  logic gyroSleep, gyroDriveOn;
  int n_mismatch = 0, tests_run = 0;
  // Rows: acc, filt, gyro, bw, then {sel, en, gs, gd, 3'b0}
  afc_row_t rows [15] = '{
    48'h01_10_00_0032_20, 48'h05_14_11_0064_78, 48'h06_1C_10_00C8_60,
    48'h07_18_03_0190_E8, 48'h08_19_14_0190_B8, 48'h09_1A_00_0000_80,
    48'h0A_1B_00_0000_80, 48'h86_28_00_0190_E0, 48'h96_10_00_00C8_20,
    48'hA6_10_00_0064_20, 48'hB6_10_00_0032_20, 48'h44_10_00_0000_00,
    48'h41_10_00_0000_00, 48'h46_10_00_00C8_20, 48'h00_10_00_0000_00};

  // Free-running clock, 10 ns period
  always #5 clock = ~clock;

  // ----------------------------------------------------------------
  // Design and converter model
  // ----------------------------------------------------------------
  afc_filter_chain #(.W(W)) uut (
    .clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rawSample(rawSample), .outData(), .irqData(), .slopeData(slopeData), .orientData(),
    .sampleStb(sampleStb), .aaEnable(aaEnable), .aaBandwidth(aaBandwidth),
    .gyroSleep(gyroSleep), .gyroDriveOn(gyroDriveOn)
  );
  afc_sample_source #(.W(W)) src (
    .clock(clock), .rstn(rstn), .sampleStb(sampleStb), .rawSample(rawSample)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  // Compare and count; an unknown bit matches only an unknown
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer, answer taken at the ready edge
  task automatic apb(input logic wr, input logic [7:0] addr, input logic [31:0] wdata,
                     output logic [31:0] rdata, output logic err);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wdata;
    @(posedge clock);
    penable <= 1'b1;
    do
    begin
      @(posedge clock);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    chk("pready", pready, 1'b1);
    rdata = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Count cycles up to the next sample strobe, giving up after lim
  task automatic waitStb(input int lim, output int n);
    n = 0;
    do
    begin
      @(negedge clock);
      n++;
    end
    while (sampleStb !== 1'b1 && n < lim);
  endtask

  // Verdict and end of run
  task automatic end_sim();
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Watchdog: the run needs about 80000 cycles
  initial
  begin
    repeat (90000) @(posedge clock);
    n_mismatch++;
    end_sim();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    logic [31:0] rd;
    logic err;
    int n;
    repeat (10) @(posedge clock);
    rstn <= 1'b1;
    // Table of configurations
    foreach (rows[i])
    begin
      apb(1'b1, AFC_OFF_ACCEL_CTRL, {24'h0, rows[i].acc}, rd, err);
      apb(1'b1, AFC_OFF_FILT_CTRL, {24'h0, rows[i].filt}, rd, err);
      apb(1'b1, AFC_OFF_GYRO_CTRL, {24'h0, rows[i].gyro}, rd, err);
      repeat (4) @(negedge clock);
      chk("aaEnable", aaEnable, rows[i].en);
      chk("aaBandwidth", aaBandwidth, rows[i].bw);
      chk("gyroSleep", gyroSleep, rows[i].gs);
      chk("gyroDriveOn", gyroDriveOn, rows[i].gd);
      apb(1'b0, AFC_OFF_STATUS, 32'h0, rd, err);
      chk("status", rd, {14'h0, rows[i].sel, rows[i].bw});
      apb(1'b0, AFC_OFF_ACCEL_CTRL, 32'h0, rd, err);
      chk("accel ctrl", rd, {24'h0, rows[i].acc});
    end
    // Unmapped read and unaligned write are refused
    apb(1'b0, 8'h1C, 32'h0, rd, err);
    chk("unmapped err", err, 1'b1);
    chk("unmapped data", rd, 32'h0);
    apb(1'b1, 8'h02, 32'h000000FF, rd, err);
    chk("unaligned err", err, 1'b1);
    apb(1'b0, AFC_OFF_ACCEL_CTRL, 32'h0, rd, err);
    chk("unaligned ignored", rd, 32'h0);
    // Slope stream at the top rate; the ramp steps by -6 per sample
    apb(1'b1, AFC_OFF_FILT_CTRL, 32'h00000018, rd, err);
    apb(1'b1, AFC_OFF_ACCEL_CTRL, {28'h0, AFC_RATE_MAX}, rd, err);
    waitStb(20000, n);
    waitStb(20000, n);
    chk("sample period", n, PERIOD_A);
    repeat (2) waitStb(20000, n);
    repeat (3) @(negedge clock);
    chk("slopeData", {16'h0, slopeData}, 32'h0000FFFD);
    apb(1'b0, AFC_OFF_DATA_SLOPE, 32'h0, rd, err);
    chk("slope reg", rd, 32'hFFFFFFFD);
    // Power-down stops sampling, data kept
    apb(1'b1, AFC_OFF_ACCEL_CTRL, 32'h0, rd, err);
    repeat (4) @(negedge clock);
    waitStb(16000, n);
    chk("power-down strobes", n, 16000);
    chk("slope kept", {16'h0, slopeData}, 32'h0000FFFD);
    // Reset in mid-run clears outputs and registers
    @(posedge clock);
    rstn <= 1'b0;
    repeat (2) @(negedge clock);
    chk("slope in reset", {16'h0, slopeData}, 32'h0);
    chk("aaEnable in reset", aaEnable, 1'b0);
    @(posedge clock);
    rstn <= 1'b1;
    apb(1'b0, AFC_OFF_ACCEL_CTRL, 32'h0, rd, err);
    chk("accel reset", rd, {24'h0, AFC_RST_ACCEL_CTRL});
    apb(1'b0, AFC_OFF_FILT_CTRL, 32'h0, rd, err);
    chk("filt reset", rd, {24'h0, AFC_RST_FILT_CTRL});
    apb(1'b0, AFC_OFF_GYRO_CTRL, 32'h0, rd, err);
    chk("gyro reset", rd, {24'h0, AFC_RST_GYRO_CTRL});
    end_sim();
  end
endmodule
